// File: hw/tpp_thermal_parity.sv
// Function
// - Warning entry pulls event line low and sets warning event flag.
// - Thermal flag is 1 in every response while a thermal event is flagged.
// - Warning level bit stays 1 while warning persists, whatever the flag clearing.
// - Warning with keep bit 0 lowers 10 mA and 15 mA inputs to 2 mA.
// - Warning leaves 0, 1, 2 and 5 mA inputs at their programmed setting.
// - Reduced current stays until warning indication falls below release point.
// - Host reads event register in one select-low frame; clear on select rise.
// - No further interrupt after clearing while condition stays above release point.
// - Keep bit set skips reduction for its group; interrupt and flags still happen.
// - Keep-full-current handling is identical in polling and continuous modes.
// - Warning exit re-asserts line, sets warning flag, clears level, restores currents.
// - Shutdown entry opens every current source and sink switch.
// - Shutdown entry pulls event line low and sets shutdown event flag.
// - During shutdown shutdown level is 1 and warning level stays 1.
// - Shutdown keeps serial link running and all register contents intact.
// - Shutdown exit re-asserts line, sets flag, clears level, keeps warning handling.
// - After shutdown restart polling, flag switch change after first cycle, store defaults.
// - Transmitted frames carry parity making the count of ones odd.
// - Host sends odd parity; device discards received frames with even count.
// - Receive parity failure pulls event line low and sets parity error flag.
// - Pending parity error is reported in the response status field.
// - Reading event register with line low releases line and clears on select rise.
`timescale 1ns/1ns
`default_nettype none

`include "tpp_regs.svh"

module tpp_thermal_parity (
	input  wire logic                            ref_clk,
	input  wire logic                            srst,
	input  wire logic                            spi_sclk,
	input  wire logic                            spi_cs_n,
	input  wire logic                            spi_mosi,
	output logic                                 spi_miso,
	output logic                                 spi_miso_oe_n,
	input  wire logic                            heat_warning_raw,
	input  wire logic                            overheat_shutdown_raw,
	input  wire logic                            keep_full_current_grp_a,
	input  wire logic                            keep_full_current_grp_b,
	input  wire logic [`TPP_NCH-1:0]             grp_b_sel,
	input  wire logic [`TPP_NCH*`TPP_WC_W-1:0]   wc_cfg,
	input  wire logic                            poll_cycle_done,
	output logic [`TPP_NCH*`TPP_WC_W-1:0]        wc_applied,
	output logic [`TPP_NCH-1:0]                  wc_switch_en,
	output logic                                 event_n,
	output logic [`TPP_EVT_W-1:0]                event_flags,
	output logic                                 heat_warning_level,
	output logic                                 overheat_shutdown_level,
	output logic                                 poll_restart,
	output logic                                 store_default_status,
	output logic                                 rx_valid,
	output logic [`TPP_FRAME_W-1:0]              rx_frame
);

	// ==========================================================
	// Helpers
	function automatic logic wc_is_high(input logic [`TPP_WC_W-1:0] code);
		wc_is_high = (code == `TPP_WC_10MA) || (code == `TPP_WC_15MA);
	endfunction

	function automatic logic odd_par(input logic [`TPP_FRAME_W-2:0] data);
		odd_par = ~(^data);
	endfunction

	// ==========================================================
	// Link domain
	logic [`TPP_FRAME_W-1:0] snap_ff;
	logic                    miso_ff;
	logic                    miso_oe_n_ff;
	logic [`TPP_FRAME_W-1:0] link_word;
	logic [`TPP_CNT_W-1:0]   link_len;

	tpp_spi_link u_link (
		.spi_sclk     (spi_sclk),
		.spi_cs_n     (spi_cs_n),
		.spi_mosi     (spi_mosi),
		.tx_word      (snap_ff),
		.miso_ff      (miso_ff),
		.miso_oe_n_ff (miso_oe_n_ff),
		.rx_word_ff   (link_word),
		.rx_len_ff    (link_len)
	);

	assign spi_miso      = miso_ff;
	assign spi_miso_oe_n = miso_oe_n_ff;

	// ==========================================================
	// Input synchronisation and transitions
	logic [2:0] sync_q;
	logic       warn_s;
	logic       shut_s;
	logic       sel_s;
	logic       warn_d_ff;
	logic       shut_d_ff;
	logic       sel_d_ff;

	tpp_sync #(.W(3)) u_sync (
		.clk  (ref_clk),
		.srst (srst),
		.d    ({~spi_cs_n, overheat_shutdown_raw, heat_warning_raw}),
		.q    (sync_q)
	);

	assign warn_s = sync_q[0];
	assign shut_s = sync_q[1];
	assign sel_s  = sync_q[2];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			warn_d_ff <= 1'h0;
			shut_d_ff <= 1'h0;
			sel_d_ff  <= 1'h0;
		end else begin
			warn_d_ff <= warn_s;
			shut_d_ff <= shut_s;
			sel_d_ff  <= sel_s;
		end
	end

	logic warn_rise;
	logic warn_fall;
	logic shut_rise;
	logic shut_fall;
	logic frame_end;

	// Sensor levels already carry hysteresis, so edges are the entry and exit points
	assign warn_rise = warn_s & ~warn_d_ff;
	assign warn_fall = ~warn_s & warn_d_ff;
	assign shut_rise = shut_s & ~shut_d_ff;
	assign shut_fall = ~shut_s & shut_d_ff;
	// Link word and length are idle once select has been high two cycles
	assign frame_end = ~sel_s & sel_d_ff;

	// ==========================================================
	// Receive frame check
	logic frame_full;
	logic par_ok;
	logic par_fail;
	logic good_frame;
	logic evt_read;

	assign frame_full = frame_end && (link_len == `TPP_FRAME_LEN);
	assign par_ok     = ^link_word;
	assign par_fail   = frame_full & ~par_ok;
	assign good_frame = frame_full & par_ok;
	assign evt_read   = good_frame
		&& (link_word[`TPP_RW_BIT] == `TPP_RW_READ)
		&& (link_word[`TPP_ADDR_HI:`TPP_ADDR_LO] == `TPP_EVT_ADDR);

	logic                    rx_valid_ff;
	logic [`TPP_FRAME_W-1:0] rx_frame_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_valid_ff <= 1'h0;
			rx_frame_ff <= '0;
		end else begin
			rx_valid_ff <= good_frame;
			if (good_frame) begin
				rx_frame_ff <= link_word;
			end
		end
	end

	assign rx_valid = rx_valid_ff;
	assign rx_frame = rx_frame_ff;

	// ==========================================================
	// Restart sequencing after shutdown
	tpp_pkg::tpp_state_t state_ff;
	tpp_pkg::tpp_state_t nxt_state;
	logic                ssc_set;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tpp_pkg::TPP_ST_RUN: begin
				if (shut_fall) begin
					nxt_state = tpp_pkg::TPP_ST_RESTART;
				end
			end
			tpp_pkg::TPP_ST_RESTART: begin
				nxt_state = tpp_pkg::TPP_ST_FIRST;
			end
			tpp_pkg::TPP_ST_FIRST: begin
				// A new shutdown abandons the restart; the next exit starts over
				if (shut_rise || poll_cycle_done) begin
					nxt_state = tpp_pkg::TPP_ST_RUN;
				end
			end
			default: begin
				nxt_state = tpp_pkg::TPP_ST_RUN;
			end
		endcase
	end

	assign ssc_set = (state_ff == tpp_pkg::TPP_ST_FIRST) && poll_cycle_done && !shut_rise;

	logic poll_restart_ff;
	logic store_default_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff         <= tpp_pkg::TPP_ST_RUN;
			poll_restart_ff  <= 1'h0;
			store_default_ff <= 1'h0;
		end else begin
			state_ff         <= nxt_state;
			poll_restart_ff  <= (nxt_state == tpp_pkg::TPP_ST_RESTART);
			store_default_ff <= ssc_set;
		end
	end

	assign poll_restart         = poll_restart_ff;
	assign store_default_status = store_default_ff;

	// ==========================================================
	// Event flags and event line
	logic [`TPP_EVT_W-1:0] evt_ff;
	logic [`TPP_EVT_W-1:0] evt_set;
	logic [`TPP_EVT_W-1:0] nxt_evt;
	logic                  evt_clr;
	logic                  event_n_ff;
	logic                  nxt_event_n;

	// Entry and exit both flag; staying above the release point raises nothing
	assign evt_set[`TPP_EVT_TW]   = warn_rise | warn_fall;
	assign evt_set[`TPP_EVT_TSD]  = shut_rise | shut_fall;
	assign evt_set[`TPP_EVT_PRTY] = par_fail;
	assign evt_set[`TPP_EVT_SSC]  = ssc_set;
	assign evt_clr = evt_read;

	// A new event in the clearing cycle survives the clear
	assign nxt_evt     = (evt_ff & ~{`TPP_EVT_W{evt_clr}}) | evt_set;
	assign nxt_event_n = (|evt_set) ? 1'h0 : (evt_clr ? 1'h1 : event_n_ff);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			evt_ff     <= `TPP_EVT_RST;
			event_n_ff <= 1'h1;
		end else begin
			evt_ff     <= nxt_evt;
			event_n_ff <= nxt_event_n;
		end
	end

	assign event_n     = event_n_ff;
	assign event_flags = evt_ff;

	// ==========================================================
	// Response word, frozen while select is low
	logic                    st_temp;
	logic [`TPP_FRAME_W-1:0] nxt_snap;

	assign st_temp  = evt_ff[`TPP_EVT_TW] | evt_ff[`TPP_EVT_TSD];
	assign nxt_snap[`TPP_ST_PRTY] = evt_ff[`TPP_EVT_PRTY];
	assign nxt_snap[`TPP_ST_TEMP] = st_temp;
	assign nxt_snap[`TPP_ST_SSC]  = evt_ff[`TPP_EVT_SSC];
	assign nxt_snap[`TPP_ST_SSC-1:`TPP_EVT_W+1] = `TPP_ST_PAD;
	assign nxt_snap[`TPP_EVT_W:1] = evt_ff;
	assign nxt_snap[`TPP_PAR_BIT] = odd_par(nxt_snap[`TPP_FRAME_W-1:1]);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			snap_ff <= {{(`TPP_FRAME_W-1){1'h0}}, 1'h1};
		end else if (!sel_s && !sel_d_ff) begin
			snap_ff <= nxt_snap;
		end
	end

	// ==========================================================
	// Level bits and wetting current control
	logic heat_level_ff;
	logic shut_level_ff;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			heat_level_ff <= 1'h0;
			shut_level_ff <= 1'h0;
		end else begin
			heat_level_ff <= warn_s | shut_s;
			shut_level_ff <= shut_s;
		end
	end

	assign heat_warning_level      = heat_level_ff;
	assign overheat_shutdown_level = shut_level_ff;

	// Shutdown only gates switches; configuration and stored status are untouched
	logic [`TPP_NCH*`TPP_WC_W-1:0] wc_applied_ff;
	logic [`TPP_NCH-1:0]           wc_switch_en_ff;

	genvar gi;
	generate
		for (gi = 0; gi < `TPP_NCH; gi = gi + 1) begin : g_ch
			logic [`TPP_WC_W-1:0] code;
			logic                 keep;
			logic                 reduce;
			assign code   = wc_cfg[gi*`TPP_WC_W +: `TPP_WC_W];
			// Same decision in polling and continuous operation
			assign keep   = grp_b_sel[gi] ? keep_full_current_grp_b
						      : keep_full_current_grp_a;
			assign reduce = warn_s & ~keep & wc_is_high(code);
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					wc_applied_ff[gi*`TPP_WC_W +: `TPP_WC_W] <= `TPP_WC_0MA;
					wc_switch_en_ff[gi] <= 1'h0;
				end else begin
					wc_applied_ff[gi*`TPP_WC_W +: `TPP_WC_W] <=
						reduce ? `TPP_WC_2MA : code;
					wc_switch_en_ff[gi] <= ~shut_s;
				end
			end
		end
	endgenerate

	assign wc_applied   = wc_applied_ff;
	assign wc_switch_en = wc_switch_en_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_shut_exit;
		shut_fall ##1 (state_ff == tpp_pkg::TPP_ST_RESTART);
	endsequence

	sequence s_restart_pulse;
		poll_restart_ff ##1 (state_ff == tpp_pkg::TPP_ST_FIRST);
	endsequence

	a_warn_entry_flag: assert property (warn_rise |=> evt_ff[`TPP_EVT_TW] && !event_n_ff)
		else $error("warning entry did not flag");
	a_temp_in_resp: assert property ((st_temp && !sel_s && !sel_d_ff) |=> snap_ff[`TPP_ST_TEMP])
		else $error("thermal flag missing from response");
	a_warn_level_hold: assert property (warn_s |=> heat_level_ff)
		else $error("warning level dropped while warning");
	a_cur_reduce_ch0: assert property ((warn_s && !grp_b_sel[0] && !keep_full_current_grp_a
		&& wc_is_high(wc_cfg[`TPP_WC_W-1:0])) |=> wc_applied_ff[`TPP_WC_W-1:0] == `TPP_WC_2MA)
		else $error("high current not reduced");
	a_cur_keep_low: assert property ((!wc_is_high(wc_cfg[`TPP_WC_W-1:0]) && $stable(wc_cfg))
		|=> wc_applied_ff[`TPP_WC_W-1:0] == $past(wc_cfg[`TPP_WC_W-1:0]))
		else $error("low current setting altered");
	a_keep_full: assert property ((warn_s && !grp_b_sel[0] && keep_full_current_grp_a)
		|=> wc_applied_ff[`TPP_WC_W-1:0] == $past(wc_cfg[`TPP_WC_W-1:0]))
		else $error("keep bit ignored");
	a_read_clears: assert property ((evt_clr && !(|evt_set)) |=> evt_ff == `TPP_EVT_RST && event_n_ff)
		else $error("event read did not clear");
	a_shut_opens: assert property (shut_s |=> wc_switch_en_ff == '0)
		else $error("switches closed during shutdown");
	a_shut_entry: assert property (shut_rise |=> evt_ff[`TPP_EVT_TSD] && !event_n_ff && heat_level_ff)
		else $error("shutdown entry not flagged");
	a_restart_seq: assert property (s_shut_exit |-> s_restart_pulse)
		else $error("polling restart sequence broken");
	a_tx_odd: assert property (!sel_s |=> ^snap_ff)
		else $error("response parity even");
	a_bad_dropped: assert property (par_fail |=> !rx_valid_ff && evt_ff[`TPP_EVT_PRTY] && !event_n_ff)
		else $error("bad frame accepted");

endmodule

`default_nettype wire

// File: hw/tpp_regs.svh
`ifndef TPP_REGS_SVH
`define TPP_REGS_SVH

// ==========================================================
// Serial frame layout
`define TPP_FRAME_W        32
`define TPP_CNT_W          6
`define TPP_FRAME_LEN      6'h20
`define TPP_MSB_IDX        5'h1f
`define TPP_CNT_STEP       6'h01
`define TPP_RW_BIT         31
`define TPP_ADDR_HI        30
`define TPP_ADDR_LO        25
`define TPP_PAR_BIT        0
`define TPP_RW_READ        1'h0
`define TPP_EVT_ADDR       6'h01

// ==========================================================
// Response status field
`define TPP_ST_PRTY        31
`define TPP_ST_TEMP        30
`define TPP_ST_SSC         29
`define TPP_ST_PAD_W       24
`define TPP_ST_PAD         24'h000000

// ==========================================================
// Event flag register
`define TPP_EVT_W          4
`define TPP_EVT_TW         0
`define TPP_EVT_TSD        1
`define TPP_EVT_PRTY       2
`define TPP_EVT_SSC        3
`define TPP_EVT_RST        4'h0

// ==========================================================
// Wetting current codes and channel map
`define TPP_NCH            24
`define TPP_WC_W           3
`define TPP_WC_0MA         3'h0
`define TPP_WC_1MA         3'h1
`define TPP_WC_2MA         3'h2
`define TPP_WC_5MA         3'h3
`define TPP_WC_10MA        3'h4
`define TPP_WC_15MA        3'h5

`endif

// File: hw/tpp_pkg.sv
`default_nettype none

package tpp_pkg;

	// Restart sequencing after an overheat shutdown ends
	typedef enum logic [2:0] {
		TPP_ST_RUN     = 3'h1,
		TPP_ST_RESTART = 3'h2,
		TPP_ST_FIRST   = 3'h4
	} tpp_state_t;

endpackage

`default_nettype wire

// File: hw/tpp_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Two-stage level synchroniser, clears to zero on reset
module tpp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule

`default_nettype wire

// File: hw/tpp_spi_link.sv
`timescale 1ns/1ns
`default_nettype none

`include "tpp_regs.svh"

// ==========================================================
// Link-side shifter: master drives on rising sclk, device samples on falling
module tpp_spi_link (
	input  wire logic                     spi_sclk,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_mosi,
	input  wire logic [`TPP_FRAME_W-1:0]  tx_word,
	output logic                          miso_ff,
	output logic                          miso_oe_n_ff,
	output logic [`TPP_FRAME_W-1:0]       rx_word_ff,
	output logic [`TPP_CNT_W-1:0]         rx_len_ff
);

	logic [`TPP_CNT_W-1:0] cnt_ff;
	logic                  tx_bit;

	// Core keeps tx_word frozen while chip select is low
	assign tx_bit = tx_word[`TPP_MSB_IDX - cnt_ff[4:0]];

	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + `TPP_CNT_STEP;
		end
	end

	// Word and length hold after the frame so the core can read them once select is high
	always_ff @(negedge spi_sclk) begin
		rx_word_ff <= {rx_word_ff[`TPP_FRAME_W-2:0], spi_mosi};
		rx_len_ff  <= cnt_ff + `TPP_CNT_STEP;
	end

	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			miso_ff      <= 1'h0;
			miso_oe_n_ff <= 1'h1;
		end else begin
			miso_ff      <= tx_bit;
			miso_oe_n_ff <= 1'h0;
		end
	end

endmodule

`default_nettype wire

// File: tb/tpp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Serial master: link clock runs only inside frames, 64 ns period
module tpp_host_model (
	output logic    spi_sclk,
	output logic    spi_cs_n,
	output logic    spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n
);
	initial begin
		spi_sclk = 1'b0;
		spi_mosi = 1'b0;
		// Late rise so the link's select reset sees a real edge at start
		#1;
		spi_cs_n = 1'b1;
	end

	// Drives data on rising clock, samples reply just before falling clock
	task automatic xfer(input logic [31:0] w, output logic [31:0] r, output logic oe_bad);
		int k;
		oe_bad = 1'b0;
		r = 32'h00000000;
		#17;
		spi_cs_n = 1'b0;
		// Select setup: first edge not before 400 ns
		#400;
		for (k = 31; k >= 0; k--) begin
			spi_sclk = 1'b1;
			spi_mosi = w[k];
			#32;
			r[k] = spi_miso;
			oe_bad = oe_bad | spi_miso_oe_n;
			spi_sclk = 1'b0;
			#32;
		end
		// One whole command per select-low window
		spi_cs_n = 1'b1;
		// Released data line must not keep showing the last bit
		spi_mosi = ~spi_mosi;
		#400;
	endtask
endmodule

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

`include "tpp_regs.svh"

module tb;
	logic                          ref_clk = 1'b0;
	logic                          srst = 1'b1;
	wire logic                     spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
	logic                          warn_raw, shut_raw, keep_a, keep_b, poll_done;
	logic [`TPP_NCH-1:0]           grp_b_sel;
	logic [`TPP_NCH*`TPP_WC_W-1:0] wc_cfg, wc_applied;
	logic [`TPP_NCH-1:0]           wc_switch_en;
	logic                          event_n, warn_lvl, shut_lvl, poll_restart, store_dflt, rx_valid;
	logic [`TPP_EVT_W-1:0]         event_flags, exp_flags;
	logic [`TPP_FRAME_W-1:0]       rx_frame;
	logic                          exp_evn, exp_wl, exp_sl, seen;
	logic [31:0]                   rxq[$];
	int                            seed = 26569;
	int                            error_cnt = 0;
	int                            n_checks = 0;
	int                            i, off;

	always #50 ref_clk = ~ref_clk;

	tpp_thermal_parity dut_u (
		.ref_clk(ref_clk), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.heat_warning_raw(warn_raw), .overheat_shutdown_raw(shut_raw),
		.keep_full_current_grp_a(keep_a), .keep_full_current_grp_b(keep_b),
		.grp_b_sel(grp_b_sel), .wc_cfg(wc_cfg), .poll_cycle_done(poll_done),
		.wc_applied(wc_applied), .wc_switch_en(wc_switch_en), .event_n(event_n),
		.event_flags(event_flags), .heat_warning_level(warn_lvl),
		.overheat_shutdown_level(shut_lvl), .poll_restart(poll_restart),
		.store_default_status(store_dflt), .rx_valid(rx_valid), .rx_frame(rx_frame)
	);

	tpp_host_model host_u (
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n)
	);

	// ==========================================================
	// Checking helpers
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_state();
		@(negedge ref_clk);
		chk("event_n", 72'(exp_evn), 72'(event_n));
		chk("event_flags", 72'(exp_flags), 72'(event_flags));
		chk("warn_level", 72'(exp_wl), 72'(warn_lvl));
		chk("shut_level", 72'(exp_sl), 72'(shut_lvl));
		chk("miso_idle", 72'(1'b1), 72'(spi_miso_oe_n));
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	function automatic logic [71:0] exp_wc(input logic warn);
		logic [71:0] r;
		logic [2:0]  c;
		logic        kp;
		for (int k = 0; k < `TPP_NCH; k++) begin
			c = wc_cfg[3*k +: 3];
			kp = grp_b_sel[k] ? keep_b : keep_a;
			r[3*k +: 3] = (warn && !kp && (c == `TPP_WC_10MA || c == `TPP_WC_15MA))
				? `TPP_WC_2MA : c;
		end
		return r;
	endfunction

	function automatic logic [31:0] resp_of(input logic [3:0] f);
		logic [30:0] u;
		u = {f[`TPP_EVT_PRTY], f[`TPP_EVT_TW] | f[`TPP_EVT_TSD], f[`TPP_EVT_SSC], `TPP_ST_PAD, f};
		return {u, ~^u};
	endfunction

	// Good frames are noted for the receive monitor; bad ones must never show up
	task automatic send(input logic [31:0] body, input logic bad);
		logic [31:0] w, r, e;
		logic        oe_bad;
		w = {body[31:1], (~^body[31:1]) ^ bad};
		e = resp_of(exp_flags);
		if (!bad)
			rxq.push_back(w);
		host_u.xfer(w, r, oe_bad);
		chk("response", 72'(e), 72'(r));
		chk("miso_oe_n", 72'(1'b0), 72'(oe_bad));
		wait_cyc(6);
		if (bad) begin
			exp_flags[`TPP_EVT_PRTY] = 1'b1;
			exp_evn = 1'b0;
		end else if (w[`TPP_RW_BIT] == `TPP_RW_READ && w[`TPP_ADDR_HI:`TPP_ADDR_LO] == `TPP_EVT_ADDR) begin
			exp_flags = `TPP_EVT_RST;
			exp_evn = 1'b1;
		end
	endtask

	task automatic rd_evt();
		send({`TPP_RW_READ, `TPP_EVT_ADDR, 25'h0000000}, 1'b0);
	endtask

	always @(negedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			if (rxq.size() == 0) begin
				error_cnt++;
				$display("[FAIL] rx_frame expected none seen %h", rx_frame);
			end else
				chk("rx_frame", 72'(rxq.pop_front()), 72'(rx_frame));
		end
	end

	initial begin
		#1000000;
		error_cnt++;
		$display("[FAIL] watchdog expected done seen timeout");
		results();
	end

	// ==========================================================
	// Main sequence
	initial begin
		warn_raw = 1'b0;
		shut_raw = 1'b0;
		keep_a = 1'b0;
		keep_b = 1'b1;
		poll_done = 1'b0;
		off = $random(seed) & 7;
		grp_b_sel = 24'($random(seed));
		// Channel 0 is pinned so the channel 0 checks in the design get exercised
		grp_b_sel[0] = 1'b0;
		for (i = 0; i < `TPP_NCH; i++)
			wc_cfg[3*i +: 3] = 3'((i + off) % 6);
		wc_cfg[2:0] = `TPP_WC_15MA;
		exp_flags = `TPP_EVT_RST;
		exp_evn = 1'b1;
		exp_wl = 1'b0;
		exp_sl = 1'b0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		wait_cyc(6);
		chk_state();
		chk("switch_en", 72'(24'hffffff), 72'(wc_switch_en));
		chk("wc_idle", exp_wc(1'b0), wc_applied);
		for (i = 0; i < 4; i++)
			send($random(seed), 1'b0);
		send($random(seed), 1'b1);
		chk_state();
		send($random(seed), 1'b0);
		rd_evt();
		chk_state();
		@(posedge ref_clk) warn_raw <= 1'b1;
		wait_cyc(6);
		exp_flags[`TPP_EVT_TW] = 1'b1;
		exp_evn = 1'b0;
		exp_wl = 1'b1;
		chk_state();
		chk("wc_warn", exp_wc(1'b1), wc_applied);
		@(posedge ref_clk) begin
			keep_a <= 1'b1;
			keep_b <= 1'b0;
			wc_cfg[2:0] <= `TPP_WC_5MA;
		end
		wait_cyc(4);
		chk("wc_keep", exp_wc(1'b1), wc_applied);
		rd_evt();
		wait_cyc(20);
		chk_state();
		@(posedge ref_clk) shut_raw <= 1'b1;
		wait_cyc(6);
		exp_flags[`TPP_EVT_TSD] = 1'b1;
		exp_evn = 1'b0;
		exp_sl = 1'b1;
		chk_state();
		chk("switch_shut", 72'(24'h000000), 72'(wc_switch_en));
		send($random(seed), 1'b0);
		rd_evt();
		chk_state();
		@(posedge ref_clk) shut_raw <= 1'b0;
		seen = 1'b0;
		for (i = 0; i < 10 && !seen; i++) begin
			@(negedge ref_clk);
			if (poll_restart === 1'b1)
				seen = 1'b1;
		end
		chk("poll_restart", 72'(1'b1), 72'(seen));
		wait_cyc(3);
		exp_flags[`TPP_EVT_TSD] = 1'b1;
		exp_evn = 1'b0;
		exp_sl = 1'b0;
		chk_state();
		chk("switch_back", 72'(24'hffffff), 72'(wc_switch_en));
		chk("wc_still_low", exp_wc(1'b1), wc_applied);
		@(posedge ref_clk) poll_done <= 1'b1;
		@(posedge ref_clk) poll_done <= 1'b0;
		seen = 1'b0;
		for (i = 0; i < 5 && !seen; i++) begin
			@(negedge ref_clk);
			if (store_dflt === 1'b1)
				seen = 1'b1;
		end
		chk("store_default", 72'(1'b1), 72'(seen));
		wait_cyc(2);
		exp_flags[`TPP_EVT_SSC] = 1'b1;
		chk_state();
		rd_evt();
		@(posedge ref_clk) warn_raw <= 1'b0;
		wait_cyc(6);
		exp_flags[`TPP_EVT_TW] = 1'b1;
		exp_evn = 1'b0;
		exp_wl = 1'b0;
		chk_state();
		chk("wc_resume", exp_wc(1'b0), wc_applied);
		rd_evt();
		chk_state();
		chk("rx_left", 72'h0, 72'(rxq.size()));
		results();
	end
endmodule

`default_nettype wire
